// file: rtl/dea_pkg.sv
package dea_pkg;

  // Clock and cycle timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int WRITE_TIME_NS = 2000;
  localparam int READ_TIME_NS = 100;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLES = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WR_LOAD = 8'(WRITE_CYCLES - 1);
  localparam logic [7:0] RD_LOAD = 8'(READ_CYCLES - 1);

  // Array geometry
  localparam int ADDR_W = 7;
  localparam int DEPTH = 128;

  // Special function register map of the device
  localparam logic [7:0] SFR_NV_ADDR = 8'h1A;
  localparam logic [7:0] SFR_NV_DATA = 8'h1B;
  localparam logic [7:0] SFR_PTR1 = 8'h03;
  localparam logic [7:0] SFR_IND1 = 8'h02;
  localparam logic [7:0] SFR_BANK = 8'h04;
  localparam logic [7:0] SFR_INTCTL = 8'h10;
  localparam logic [7:0] SFR_INTFLAG = 8'h11;
  localparam logic [7:0] CTRL_LOC = 8'h40;
  localparam logic [7:0] CTRL_BANK = 8'h01;
  localparam logic [7:0] BANK_ZERO = 8'h00;

  // Control register bits
  localparam int CTL_RD = 0;
  localparam int CTL_READ_PERMIT = 1;
  localparam int CTL_WR = 2;
  localparam int CTL_WRITE_PERMIT = 3;
  localparam logic [3:0] CTL_RESET = 4'h0;
  localparam logic [7:0] CTL_RD_PERMIT = 8'h02;
  localparam logic [7:0] CTL_RD_GO = 8'h03;
  localparam logic [7:0] CTL_WR_PERMIT = 8'h08;
  localparam logic [7:0] CTL_WR_GO = 8'h0C;
  localparam logic [7:0] CTL_CLEAR = 8'h00;
  localparam logic [7:0] MASK_RD = 8'h01;
  localparam logic [7:0] MASK_WR = 8'h04;

  // Interrupt enable and flag bits
  localparam int IE_GLOBAL = 0;
  localparam int IE_EEPROM = 1;
  localparam int IE_MF = 2;
  localparam int IF_EEPROM = 0;
  localparam int IF_MF = 1;

  // APB register map of the controller
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_ADDR = 8'h04;
  localparam logic [7:0] APB_DATA = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0C;
  localparam logic [7:0] APB_IRQCFG = 8'h10;
  localparam logic [7:0] APB_SVCCNT = 8'h14;
  localparam int CMD_GO = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_VERIFY = 2;

  // Step program layout
  localparam logic [4:0] PC_RD = 5'h00;
  localparam logic [4:0] PC_WR = 5'h0A;
  localparam logic [4:0] PC_WR_END = 5'h15;
  localparam logic [4:0] PC_SV = 5'h16;

  typedef enum logic [2:0] {K_WR, K_POLL, K_CAP, K_ACK, K_END} dea_kind_t;
  typedef enum logic [2:0] {D_CONST, D_ADDR, D_DATA, D_IE_OFF, D_IE_ON} dea_dsel_t;

  typedef struct packed {
    dea_kind_t kind;
    logic [7:0] addr;
    dea_dsel_t dsel;
    logic [7:0] value;
  } dea_step_t;

endpackage : dea_pkg

// file: rtl/dea_link_if.sv
`timescale 1ns/1ps
interface dea_link_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic [7:0] sfr_addr;
  logic sfr_we;
  logic sfr_re;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic vector_req;
  logic vector_ack;

  modport device (
    input pclk,
    input presetn,
    input sfr_addr,
    input sfr_we,
    input sfr_re,
    input sfr_wdata,
    input vector_ack,
    output sfr_rdata,
    output vector_req
  );

  modport core (
    input pclk,
    input presetn,
    output sfr_addr,
    output sfr_we,
    output sfr_re,
    output sfr_wdata,
    output vector_ack,
    input sfr_rdata,
    input vector_req
  );
endinterface : dea_link_if

// file: rtl/dea_device.sv
`timescale 1ns/1ps
module dea_device (
  dea_link_if.device link,
  output logic write_busy,
  output logic read_busy
);
  logic [6:0] nv_address_reg;
  logic [7:0] nv_data_reg;
  logic [3:0] nv_control_reg;
  logic [3:0] nv_control_next;
  logic [7:0] bank_selector_reg;
  logic [7:0] indirect_pointer_one_reg;
  logic [2:0] irq_ctl_reg;
  logic [1:0] irq_flag_reg;
  logic [1:0] irq_flag_next;
  logic [7:0] timer_reg;
  logic [7:0] mem_reg [dea_pkg::DEPTH];

  wire wr_addr = link.sfr_we && link.sfr_addr == dea_pkg::SFR_NV_ADDR;
  wire wr_data = link.sfr_we && link.sfr_addr == dea_pkg::SFR_NV_DATA;
  wire wr_ptr = link.sfr_we && link.sfr_addr == dea_pkg::SFR_PTR1;
  wire wr_bank = link.sfr_we && link.sfr_addr == dea_pkg::SFR_BANK;
  wire wr_ictl = link.sfr_we && link.sfr_addr == dea_pkg::SFR_INTCTL;
  wire wr_iflg = link.sfr_we && link.sfr_addr == dea_pkg::SFR_INTFLAG;
  wire ctrl_sel = indirect_pointer_one_reg == dea_pkg::CTRL_LOC
    && bank_selector_reg == dea_pkg::CTRL_BANK;
  wire wr_busy = nv_control_reg[dea_pkg::CTL_WR];
  wire rd_busy = nv_control_reg[dea_pkg::CTL_RD];
  wire ctrl_wr = link.sfr_we && link.sfr_addr == dea_pkg::SFR_IND1 && ctrl_sel
    && !wr_busy; // RULE22
  wire start_wr = ctrl_wr && link.sfr_wdata[dea_pkg::CTL_WR]
    && nv_control_reg[dea_pkg::CTL_WRITE_PERMIT] && !link.sfr_wdata[dea_pkg::CTL_RD]
    && !rd_busy; // RULE17
  wire start_rd = ctrl_wr && link.sfr_wdata[dea_pkg::CTL_RD]
    && nv_control_reg[dea_pkg::CTL_READ_PERMIT] && !link.sfr_wdata[dea_pkg::CTL_WR]
    && !rd_busy; // RULE18
  wire timer_zero = timer_reg == 8'h00;
  wire wr_done = wr_busy && timer_zero;
  wire rd_done = rd_busy && timer_zero;
  // Write completion raises both the source and the group request
  wire irq_set = wr_done; // RULE1

  assign write_busy = wr_busy;
  assign read_busy = rd_busy;

  // Start bits self-clear when the timed cycle ends
  always_comb begin
    nv_control_next = nv_control_reg;
    if (ctrl_wr) begin
      nv_control_next[dea_pkg::CTL_WRITE_PERMIT] = link.sfr_wdata[dea_pkg::CTL_WRITE_PERMIT];
      nv_control_next[dea_pkg::CTL_READ_PERMIT] = link.sfr_wdata[dea_pkg::CTL_READ_PERMIT];
      nv_control_next[dea_pkg::CTL_WR] = start_wr; // RULE17
      nv_control_next[dea_pkg::CTL_RD] = start_rd || (rd_busy && !rd_done); // RULE18
    end else begin
      if (wr_done) begin
        nv_control_next[dea_pkg::CTL_WR] = 1'b0; // RULE17
      end
      if (rd_done) begin
        nv_control_next[dea_pkg::CTL_RD] = 1'b0; // RULE18
      end
    end
  end

  // Hardware set wins over a software clear or a vector acknowledge
  always_comb begin
    irq_flag_next = irq_flag_reg;
    if (wr_iflg) begin
      irq_flag_next = link.sfr_wdata[1:0];
    end
    if (link.vector_ack) begin
      irq_flag_next[dea_pkg::IF_MF] = 1'b0; // RULE6
    end
    if (irq_set) begin
      irq_flag_next[dea_pkg::IF_EEPROM] = 1'b1; // RULE2
      irq_flag_next[dea_pkg::IF_MF] = 1'b1; // RULE2
    end
  end

  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      nv_control_reg <= dea_pkg::CTL_RESET; // RULE20
      bank_selector_reg <= dea_pkg::BANK_ZERO;
      indirect_pointer_one_reg <= 8'h00;
      irq_ctl_reg <= 3'h0;
      irq_flag_reg <= 2'h0;
      timer_reg <= 8'h00;
    end else begin
      nv_control_reg <= nv_control_next;
      irq_flag_reg <= irq_flag_next;
      if (wr_bank) begin
        bank_selector_reg <= link.sfr_wdata;
      end
      if (wr_ptr) begin
        indirect_pointer_one_reg <= link.sfr_wdata;
      end
      if (wr_ictl) begin
        irq_ctl_reg <= link.sfr_wdata[2:0];
      end
      if (start_wr) begin
        timer_reg <= dea_pkg::WR_LOAD;
      end else if (start_rd) begin
        timer_reg <= dea_pkg::RD_LOAD;
      end else if (!timer_zero) begin
        timer_reg <= timer_reg - 8'h01;
      end
    end
  end

  // Address and data hold still while a write cycle runs
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      nv_address_reg <= 7'h00;
      nv_data_reg <= 8'h00;
    end else begin
      if (wr_addr && !wr_busy) begin
        nv_address_reg <= link.sfr_wdata[6:0]; // RULE22
      end
      if (rd_done) begin
        nv_data_reg <= mem_reg[nv_address_reg]; // RULE21
      end else if (wr_data && !wr_busy) begin
        nv_data_reg <= link.sfr_wdata; // RULE22
      end
    end
  end

  always_ff @(posedge link.pclk) begin
    if (wr_done) begin
      mem_reg[nv_address_reg] <= nv_data_reg;
    end
  end

  wire [7:0] ctrl_rdata = ctrl_sel ? {4'h0, nv_control_reg} : 8'h00; // RULE20
  assign link.sfr_rdata =
    link.sfr_addr == dea_pkg::SFR_NV_ADDR ? {1'b0, nv_address_reg} :
    link.sfr_addr == dea_pkg::SFR_NV_DATA ? nv_data_reg :
    link.sfr_addr == dea_pkg::SFR_PTR1 ? indirect_pointer_one_reg :
    link.sfr_addr == dea_pkg::SFR_IND1 ? ctrl_rdata :
    link.sfr_addr == dea_pkg::SFR_BANK ? bank_selector_reg :
    link.sfr_addr == dea_pkg::SFR_INTCTL ? {5'h00, irq_ctl_reg} :
    link.sfr_addr == dea_pkg::SFR_INTFLAG ? {6'h00, irq_flag_reg} : 8'h00;

  // Vector only with all three enables and a pending source
  assign link.vector_req = irq_ctl_reg[dea_pkg::IE_GLOBAL] && irq_ctl_reg[dea_pkg::IE_EEPROM]
    && irq_ctl_reg[dea_pkg::IE_MF] && irq_flag_reg[dea_pkg::IF_EEPROM]
    && irq_flag_reg[dea_pkg::IF_MF]; // RULE5

endmodule : dea_device

// file: rtl/dea_core.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Write completion raises write-complete request
// RULE2 - Completion sets source and group flags
// RULE3 - Firmware sets EEPROM interrupt enable first
// RULE4 - Firmware sets group interrupt enable too
// RULE5 - Vector needs all enables plus pending request
// RULE6 - Service clears group flag; firmware clears source
// RULE7 - Write start immediately follows write permit
// RULE8 - Global enable off until write starts
// RULE9 - Keep write permit cleared when idle
// RULE10 - Keep bank selector at zero normally
// RULE11 - Optional read-back check of written byte
// RULE12 - Read: address, pointer 040H, bank 01H, permit
// RULE13 - Set read start, poll clear, fetch data
// RULE14 - Write: address, data, permit, then start
// RULE15 - Poll write start until hardware clears
// RULE16 - Clear control register then bank selector
// RULE17 - Write start needs permit; self-clears at end
// RULE18 - Read start needs permit; self-clears at end
// RULE19 - Never both starts or all four bits
// RULE20 - Control low bits reset zero; upper zero
// RULE21 - Data register holds until next operation
// RULE22 - Control writes ignored during write cycle
module dea_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dea_link_if.core link
);
  logic [4:0] pc_reg;
  logic busy_reg;
  logic svc_reg;
  logic verify_reg;
  logic vphase_reg;
  logic done_reg;
  logic vfail_reg;
  logic [6:0] addr_reg;
  logic [7:0] data_reg;
  logic [7:0] rdata_reg;
  logic [1:0] cfg_reg;
  logic [7:0] svc_cnt_reg;
  logic [31:0] prdata_reg;
  dea_pkg::dea_step_t step;

  // Fixed firmware program, one SFR access per cycle
  function automatic dea_pkg::dea_step_t dea_prog(input logic [4:0] pc);
    dea_pkg::dea_step_t s;
    s = '{dea_pkg::K_END, 8'h00, dea_pkg::D_CONST, 8'h00};
    case (pc)
      5'h00: s = '{dea_pkg::K_WR, dea_pkg::SFR_NV_ADDR, dea_pkg::D_ADDR, 8'h00}; // RULE12
      5'h01: s = '{dea_pkg::K_WR, dea_pkg::SFR_PTR1, dea_pkg::D_CONST, dea_pkg::CTRL_LOC}; // RULE12
      5'h02: s = '{dea_pkg::K_WR, dea_pkg::SFR_BANK, dea_pkg::D_CONST, dea_pkg::CTRL_BANK}; // RULE12
      5'h03: s = '{dea_pkg::K_WR, dea_pkg::SFR_IND1, dea_pkg::D_CONST,
                   dea_pkg::CTL_RD_PERMIT}; // RULE12
      5'h04: s = '{dea_pkg::K_WR, dea_pkg::SFR_IND1, dea_pkg::D_CONST,
                   dea_pkg::CTL_RD_GO}; // RULE13
      5'h05: s = '{dea_pkg::K_POLL, dea_pkg::SFR_IND1, dea_pkg::D_CONST,
                   dea_pkg::MASK_RD}; // RULE13
      5'h06: s = '{dea_pkg::K_WR, dea_pkg::SFR_IND1, dea_pkg::D_CONST,
                   dea_pkg::CTL_CLEAR}; // RULE16
      5'h07: s = '{dea_pkg::K_WR, dea_pkg::SFR_BANK, dea_pkg::D_CONST,
                   dea_pkg::BANK_ZERO}; // RULE10
      5'h08: s = '{dea_pkg::K_CAP, dea_pkg::SFR_NV_DATA, dea_pkg::D_CONST, 8'h00}; // RULE13
      5'h0A: s = '{dea_pkg::K_WR, dea_pkg::SFR_INTCTL, dea_pkg::D_IE_OFF, 8'h00}; // RULE8
      5'h0B: s = '{dea_pkg::K_WR, dea_pkg::SFR_NV_ADDR, dea_pkg::D_ADDR, 8'h00}; // RULE14
      5'h0C: s = '{dea_pkg::K_WR, dea_pkg::SFR_NV_DATA, dea_pkg::D_DATA, 8'h00}; // RULE14
      5'h0D: s = '{dea_pkg::K_WR, dea_pkg::SFR_PTR1, dea_pkg::D_CONST, dea_pkg::CTRL_LOC};
      5'h0E: s = '{dea_pkg::K_WR, dea_pkg::SFR_BANK, dea_pkg::D_CONST, dea_pkg::CTRL_BANK};
      5'h0F: s = '{dea_pkg::K_WR, dea_pkg::SFR_IND1, dea_pkg::D_CONST,
                   dea_pkg::CTL_WR_PERMIT}; // RULE14
      5'h10: s = '{dea_pkg::K_WR, dea_pkg::SFR_IND1, dea_pkg::D_CONST,
                   dea_pkg::CTL_WR_GO}; // RULE7
      5'h11: s = '{dea_pkg::K_WR, dea_pkg::SFR_INTCTL, dea_pkg::D_IE_ON, 8'h00}; // RULE8
      5'h12: s = '{dea_pkg::K_POLL, dea_pkg::SFR_IND1, dea_pkg::D_CONST,
                   dea_pkg::MASK_WR}; // RULE15
      5'h13: s = '{dea_pkg::K_WR, dea_pkg::SFR_IND1, dea_pkg::D_CONST,
                   dea_pkg::CTL_CLEAR}; // RULE9
      5'h14: s = '{dea_pkg::K_WR, dea_pkg::SFR_BANK, dea_pkg::D_CONST,
                   dea_pkg::BANK_ZERO}; // RULE16
      5'h16: s = '{dea_pkg::K_ACK, dea_pkg::SFR_INTFLAG, dea_pkg::D_CONST, 8'h00}; // RULE6
      5'h17: s = '{dea_pkg::K_WR, dea_pkg::SFR_INTFLAG, dea_pkg::D_CONST, 8'h00}; // RULE6
      default: s = '{dea_pkg::K_END, 8'h00, dea_pkg::D_CONST, 8'h00};
    endcase
    return s;
  endfunction : dea_prog

  assign step = dea_prog(pc_reg);

  wire k_wr = busy_reg && step.kind == dea_pkg::K_WR;
  wire k_poll = busy_reg && step.kind == dea_pkg::K_POLL;
  wire k_cap = busy_reg && step.kind == dea_pkg::K_CAP;
  wire k_end = busy_reg && step.kind == dea_pkg::K_END;
  wire poll_clear = (link.sfr_rdata & step.value) == 8'h00;
  // Interrupt enables carry the source and group bits set in cfg_reg
  wire [7:0] ie_off = {5'h00, cfg_reg[1], cfg_reg[0], 1'b0}; // RULE3
  wire [7:0] ie_on = {5'h00, cfg_reg[1], cfg_reg[0], 1'b1}; // RULE4

  assign link.sfr_addr = busy_reg ? step.addr : 8'h00;
  assign link.sfr_we = k_wr;
  assign link.sfr_re = k_poll || k_cap;
  assign link.vector_ack = busy_reg && step.kind == dea_pkg::K_ACK;
  // Only fixed patterns reach the control register, never both start bits together
  assign link.sfr_wdata = !busy_reg ? 8'h00 :
    step.dsel == dea_pkg::D_ADDR ? {1'b0, addr_reg} :
    step.dsel == dea_pkg::D_DATA ? data_reg :
    step.dsel == dea_pkg::D_IE_OFF ? ie_off :
    step.dsel == dea_pkg::D_IE_ON ? ie_on : step.value; // RULE19

  // APB slave, zero wait states
  wire apb_wr = psel && penable && pwrite;
  wire apb_setup = psel && !penable;
  wire hit_cmd = paddr == dea_pkg::APB_CMD;
  wire hit_addr = paddr == dea_pkg::APB_ADDR;
  wire hit_data = paddr == dea_pkg::APB_DATA;
  wire hit_stat = paddr == dea_pkg::APB_STATUS;
  wire hit_cfg = paddr == dea_pkg::APB_IRQCFG;
  wire hit_cnt = paddr == dea_pkg::APB_SVCCNT;
  wire mapped = hit_cmd || hit_addr || hit_data || hit_stat || hit_cfg || hit_cnt;
  wire go = apb_wr && hit_cmd && pwdata[dea_pkg::CMD_GO] && !busy_reg;
  wire svc_go = !busy_reg && !go && link.vector_req;
  wire to_verify = k_end && pc_reg == dea_pkg::PC_WR_END && verify_reg && !vphase_reg;
  wire [31:0] status_word = {16'h0000, rdata_reg, 5'h00, vfail_reg, done_reg, busy_reg};
  wire [31:0] rd_mux =
    hit_cmd ? {29'h0, verify_reg, 2'h0} :
    hit_addr ? {25'h0, addr_reg} :
    hit_data ? {24'h0, data_reg} :
    hit_stat ? status_word :
    hit_cfg ? {30'h0, cfg_reg} :
    hit_cnt ? {24'h0, svc_cnt_reg} : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      addr_reg <= 7'h00;
      data_reg <= 8'h00;
      cfg_reg <= 2'h0;
      verify_reg <= 1'b0;
    end else begin
      if (apb_setup) begin
        prdata_reg <= rd_mux;
      end
      if (apb_wr && hit_addr && !busy_reg) begin
        addr_reg <= pwdata[6:0];
      end
      if (apb_wr && hit_data && !busy_reg) begin
        data_reg <= pwdata[7:0];
      end
      if (apb_wr && hit_cfg) begin
        cfg_reg <= pwdata[1:0];
      end
      if (go) begin
        verify_reg <= pwdata[dea_pkg::CMD_VERIFY]; // RULE11
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= dea_pkg::PC_RD;
      busy_reg <= 1'b0;
      svc_reg <= 1'b0;
      vphase_reg <= 1'b0;
      done_reg <= 1'b0;
      vfail_reg <= 1'b0;
      rdata_reg <= 8'h00;
      svc_cnt_reg <= 8'h00;
    end else if (go) begin
      pc_reg <= pwdata[dea_pkg::CMD_WRITE] ? dea_pkg::PC_WR : dea_pkg::PC_RD;
      busy_reg <= 1'b1;
      svc_reg <= 1'b0;
      vphase_reg <= 1'b0;
      done_reg <= 1'b0;
      vfail_reg <= 1'b0;
    end else if (svc_go) begin
      pc_reg <= dea_pkg::PC_SV;
      busy_reg <= 1'b1;
      svc_reg <= 1'b1;
      svc_cnt_reg <= svc_cnt_reg + 8'h01;
    end else if (to_verify) begin
      pc_reg <= dea_pkg::PC_RD; // RULE11
      vphase_reg <= 1'b1;
    end else if (k_end) begin
      busy_reg <= 1'b0;
      done_reg <= done_reg || !svc_reg;
    end else if (busy_reg && !(k_poll && !poll_clear)) begin
      pc_reg <= pc_reg + 5'h01;
      if (k_cap && vphase_reg) begin
        vfail_reg <= link.sfr_rdata != data_reg; // RULE11
      end else if (k_cap) begin
        rdata_reg <= link.sfr_rdata;
      end
    end
  end

endmodule : dea_core

// file: dv/dea_link_props.sv
`timescale 1ns/1ps
module dea_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic vector_req,
  input wire logic vector_ack
);
  logic [7:0] ptr_reg;
  logic [7:0] bank_reg;
  logic [2:0] ie_reg;
  logic [7:0] wr_cnt_reg;
  logic [7:0] rd_cnt_reg;
  logic wr_poll_reg;
  // Control location is seen only through the indirect port when pointer and bank match
  wire ctl_rd = sfr_re && sfr_addr == dea_pkg::SFR_IND1 && ptr_reg == dea_pkg::CTRL_LOC
    && bank_reg == dea_pkg::CTRL_BANK;
  wire wr_hi = ctl_rd && sfr_rdata[dea_pkg::CTL_WR];
  wire rd_hi = ctl_rd && sfr_rdata[dea_pkg::CTL_RD];
  wire wr_end = ctl_rd && !sfr_rdata[dea_pkg::CTL_WR] && wr_poll_reg;
  wire rd_end = ctl_rd && !sfr_rdata[dea_pkg::CTL_RD] && sfr_rdata[dea_pkg::CTL_READ_PERMIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= 8'h00;
      bank_reg <= 8'h00;
      ie_reg <= 3'h0;
      wr_cnt_reg <= 8'h00;
      rd_cnt_reg <= 8'h00;
      wr_poll_reg <= 1'b0;
    end else begin
      if (sfr_we && sfr_addr == dea_pkg::SFR_PTR1) ptr_reg <= sfr_wdata;
      if (sfr_we && sfr_addr == dea_pkg::SFR_BANK) bank_reg <= sfr_wdata;
      if (sfr_we && sfr_addr == dea_pkg::SFR_INTCTL) ie_reg <= sfr_wdata[2:0];
      wr_cnt_reg <= wr_hi ? wr_cnt_reg + 8'h01 : 8'h00;
      rd_cnt_reg <= rd_hi ? rd_cnt_reg + 8'h01 : 8'h00;
      wr_poll_reg <= wr_hi;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ctl_upper_zero;
    ctl_rd |-> sfr_rdata[7:4] == 4'h0;
  endproperty
  a_ctl_upper_zero: assert property (p_ctl_upper_zero) else $error("control upper bits set");
  property p_wr_needs_permit;
    wr_hi |-> sfr_rdata[dea_pkg::CTL_WRITE_PERMIT];
  endproperty
  a_wr_needs_permit: assert property (p_wr_needs_permit) else $error("write without permit");
  property p_rd_needs_permit;
    rd_hi |-> sfr_rdata[dea_pkg::CTL_READ_PERMIT];
  endproperty
  a_rd_needs_permit: assert property (p_rd_needs_permit) else $error("read without permit");
  property p_wr_bounded;
    wr_cnt_reg <= 8'(dea_pkg::WRITE_CYCLES + 2);
  endproperty
  a_wr_bounded: assert property (p_wr_bounded) else $error("write start never cleared");
  property p_rd_bounded;
    rd_cnt_reg <= 8'(dea_pkg::READ_CYCLES + 2);
  endproperty
  a_rd_bounded: assert property (p_rd_bounded) else $error("read start never cleared");
  property p_vec_enables;
    vector_req |-> ie_reg == 3'h7;
  endproperty
  a_vec_enables: assert property (p_vec_enables) else $error("vector with enable off");
  property p_wr_end_irq;
    wr_end && ie_reg == 3'h7 |-> ##[0:2] vector_req;
  endproperty
  a_wr_end_irq: assert property (p_wr_end_irq) else $error("no request after write");
  property p_rd_no_irq;
    rd_end && !vector_req |=> !vector_req [*3];
  endproperty
  a_rd_no_irq: assert property (p_rd_no_irq) else $error("request after read");
  property p_ack_clears;
    vector_ack |=> !vector_req;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("group flag kept after service");
  c_wr_end: cover property (wr_end);
  c_rd_end: cover property (rd_end);
  c_ack: cover property (vector_ack);
endmodule : dea_link_props

// file: dv/test_data_eeprom_access_irq.sv
`timescale 1ns/1ps
module test_data_eeprom_access_irq;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic write_busy;
  logic read_busy;
  int miscompares = 0;
  int n_checks = 0;
  int seed = 32'h5D2E009B;
  int svc = 0;
  logic [7:0] mem [int];
  logic [31:0] rd_q;
  logic err_q;
  logic [6:0] a;
  logic [7:0] d;
  always #25 pclk = ~pclk;
  dea_link_if i_dea_link_if (.pclk(pclk), .presetn(presetn));
  dea_core i_dea_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(i_dea_link_if));
  dea_device i_dea_device (.link(i_dea_link_if), .write_busy(write_busy),
    .read_busy(read_busy));
  dea_link_props i_dea_link_props (.pclk(pclk), .presetn(presetn),
    .sfr_addr(i_dea_link_if.sfr_addr), .sfr_we(i_dea_link_if.sfr_we),
    .sfr_re(i_dea_link_if.sfr_re), .sfr_wdata(i_dea_link_if.sfr_wdata),
    .sfr_rdata(i_dea_link_if.sfr_rdata), .vector_req(i_dea_link_if.vector_req),
    .vector_ack(i_dea_link_if.vector_ack));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait for the answer ends once pready is high; the watchdog covers a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_idle();
    do begin
      apb(1'b0, dea_pkg::APB_STATUS, 32'h0);
    end while (rd_q[0] !== 1'b0);
  endtask : wait_idle
  task automatic run(input logic [6:0] ra, input logic [7:0] rdv, input logic [31:0] cmd);
    apb(1'b1, dea_pkg::APB_ADDR, {25'h0, ra});
    apb(1'b1, dea_pkg::APB_DATA, {24'h0, rdv});
    apb(1'b1, dea_pkg::APB_CMD, cmd);
    wait_idle();
  endtask : run
  task automatic write_op(input logic [31:0] cmd, input int counted);
    run(a, d, cmd);
    mem[a] = d;
    svc += counted;
    check("wr_status", rd_q & 32'h7, 32'h2);
  endtask : write_op
  task automatic svc_chk();
    repeat (6) @(posedge pclk);
    apb(1'b0, dea_pkg::APB_SVCCNT, 32'h0);
    check("svc_count", rd_q, 32'(svc & 8'hFF));
  endtask : svc_chk
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, dea_pkg::APB_STATUS, 32'h0);
    check("status_reset", rd_q, 32'h0);
    check("pready", {31'h0, pready}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped_err", {31'h0, err_q}, 32'h1);
    apb(1'b1, dea_pkg::APB_IRQCFG, 32'h3);
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($random(seed));
      d = 8'($random(seed));
      write_op(32'h3, 1);
      svc_chk();
    end
    foreach (mem[k]) begin
      run(7'(k), 8'($random(seed)), 32'h1);
      check("rd_data", rd_q & 32'hFF07, {16'h0, mem[k], 8'h02});
    end
    svc_chk();
    // Address, data and a second go offered mid-write must all be dropped
    a = 7'h15;
    d = 8'($random(seed));
    apb(1'b1, dea_pkg::APB_ADDR, {25'h0, a});
    apb(1'b1, dea_pkg::APB_DATA, {24'h0, d});
    apb(1'b1, dea_pkg::APB_CMD, 32'h3);
    apb(1'b1, dea_pkg::APB_ADDR, {25'h0, a ^ 7'h01});
    apb(1'b1, dea_pkg::APB_DATA, {24'h0, ~d});
    apb(1'b1, dea_pkg::APB_CMD, 32'h1);
    // The write cycle has started and no read may run beside it
    check("busy_mid", {30'h0, write_busy, read_busy}, 32'h2);
    wait_idle();
    mem[a] = d;
    svc++;
    run(a, 8'h00, 32'h1);
    check("busy_refuse", rd_q & 32'hFF07, {16'h0, d, 8'h02});
    svc_chk();
    a = 7'($random(seed));
    d = 8'($random(seed));
    write_op(32'h7, 1);
    apb(1'b0, dea_pkg::APB_CMD, 32'h0);
    check("verify_cfg", rd_q & 32'h4, 32'h4);
    svc_chk();
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, dea_pkg::APB_IRQCFG, 32'(c));
      a = 7'($random(seed));
      d = 8'($random(seed));
      write_op(32'h3, 0);
      svc_chk();
    end
    check("busy_flags", {30'h0, write_busy, read_busy}, 32'h0);
    give_verdict();
  end
endmodule : test_data_eeprom_access_irq
